// ### logic/local_memory_region_defs.vh
// constants for the local memory region setup registers and local memories
// assumes inclusion by bare name from the design files
`ifndef LOCAL_MEMORY_REGION_DEFS_VH
`define LOCAL_MEMORY_REGION_DEFS_VH

// coprocessor transfer second opcode selects
`define OP2_DATA_REGION       3'h0
`define OP2_INSTR_REGION      3'h1

// field layout of a region setup register
`define REGION_BASE_MSB       31
`define REGION_BASE_LSB       12
`define REGION_SIZE_MSB       5
`define REGION_SIZE_LSB       2
`define REGION_ENABLE_BIT     0
`define REGION_BASE_SHIFT     12

// size codes
`define SIZE_CODE_ABSENT      4'h0
`define SIZE_CODE_MIN         4'h3
`define SIZE_CODE_MAX         4'hb
`define SIZE_CODE_INSTR       4'h5
`define SIZE_CODE_DATA        4'h6

// reset values
`define REGION_BASE_RESET     20'h00000
`define REGION_ENABLE_RESET   1'h0

// local memory layout (byte offsets inside a region)
`define PAGE_SEL_BIT          13
`define WORD_IDX_LSB          2
`define RAM_ROM_SEL_BIT       14

`endif

// ### logic/local_memory_region_regs.v
// region setup registers and local memories of the processor
// assumes processor clock/reset; coprocessor transfers arrive as one-cycle strobes
`timescale 1ns/10ps
`default_nettype none
`include "local_memory_region_defs.vh"

module local_memory_region_regs #(
	parameter WORDS_PER_PAGE = 2048,
	parameter ROM_WORDS      = 4096,
	parameter ADDR_W         = 14
) (
	// clock and reset
	input  wire        i_clk,
	input  wire        i_rst,
	input  wire        i_ce,
	// coprocessor register transfer
	input  wire        i_cp_wr,
	input  wire        i_cp_rd,
	input  wire [2:0]  i_cp_op2,
	input  wire [31:0] i_cp_wdata,
	output reg  [31:0] o_cp_rdata,
	// instruction-side local memory port
	input  wire        i_ins_req,
	input  wire [31:0] i_ins_addr,
	output reg  [31:0] o_ins_rdata,
	output reg         o_ins_hit,
	output reg         o_ins_ack,
	// data-side local memory port
	input  wire        i_dat_req,
	input  wire        i_dat_we,
	input  wire [31:0] i_dat_addr,
	input  wire [31:0] i_dat_wdata,
	output reg  [31:0] o_dat_rdata,
	output reg         o_dat_hit,
	output reg         o_dat_ack,
	// region state for the processor
	output reg         o_ins_region_on,
	output reg         o_dat_region_on
);

	// ==========================================================
	// region registers
	reg  [19:0] ins_base_reg;
	reg  [19:0] dat_base_reg;
	reg         ins_en_reg;
	reg         dat_en_reg;
	wire [3:0]  ins_size = `SIZE_CODE_INSTR;
	wire [3:0]  dat_size = `SIZE_CODE_DATA;
	wire [31:0] ins_word;
	wire [31:0] dat_word;

	// size sits in 5..2, 11..6 and bit 1 read zero
	assign ins_word = {ins_base_reg, 6'h00, ins_size, 1'b0, ins_en_reg};
	assign dat_word = {dat_base_reg, 6'h00, dat_size, 1'b0, dat_en_reg};

	always @(posedge i_clk) begin
		if (i_rst) begin
			ins_base_reg <= `REGION_BASE_RESET;
			dat_base_reg <= `REGION_BASE_RESET;
			ins_en_reg   <= `REGION_ENABLE_RESET;
			dat_en_reg   <= `REGION_ENABLE_RESET;
		end else if (i_ce) begin
			// only base and enable are stored: size field writes are dropped
			if (i_cp_wr && i_cp_op2 == `OP2_DATA_REGION) begin
				dat_base_reg <= i_cp_wdata[`REGION_BASE_MSB:`REGION_BASE_LSB];
				dat_en_reg   <= i_cp_wdata[`REGION_ENABLE_BIT];
			end
			if (i_cp_wr && i_cp_op2 == `OP2_INSTR_REGION) begin
				ins_base_reg <= i_cp_wdata[`REGION_BASE_MSB:`REGION_BASE_LSB];
				ins_en_reg   <= i_cp_wdata[`REGION_ENABLE_BIT];
			end
		end
	end

	// ==========================================================
	// register read port
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_cp_rdata <= 32'h00000000;
		end else if (i_ce && i_cp_rd) begin
			case (i_cp_op2)
				`OP2_DATA_REGION:  o_cp_rdata <= dat_word;
				`OP2_INSTR_REGION: o_cp_rdata <= ins_word;
				default:           o_cp_rdata <= 32'h00000000;
			endcase
		end
	end

	// ==========================================================
	// region decode
	function [31:0] size_bytes;
		input [3:0] code;
		begin
			case (code)
				`SIZE_CODE_ABSENT: size_bytes = 32'h00000000;
				4'h3:              size_bytes = 32'h00001000;
				4'h4:              size_bytes = 32'h00002000;
				4'h5:              size_bytes = 32'h00004000;
				4'h6:              size_bytes = 32'h00008000;
				4'h7:              size_bytes = 32'h00010000;
				4'h8:              size_bytes = 32'h00020000;
				4'h9:              size_bytes = 32'h00040000;
				4'ha:              size_bytes = 32'h00080000;
				4'hb:              size_bytes = 32'h00100000;
				default:           size_bytes = 32'h00000000; // reserved codes
			endcase
		end
	endfunction

	// ==========================================================
	// address decode
	wire [31:0] ins_base_addr = {ins_base_reg, 12'h000};
	wire [31:0] dat_base_addr = {dat_base_reg, 12'h000};
	wire [31:0] ins_off       = i_ins_addr - ins_base_addr;
	wire [31:0] dat_off       = i_dat_addr - dat_base_addr;
	wire        ins_in        = ins_en_reg && (i_ins_addr >= ins_base_addr) && (ins_off < size_bytes(ins_size));
	wire        dat_in        = dat_en_reg && (i_dat_addr >= dat_base_addr) && (dat_off < size_bytes(dat_size));

	// ==========================================================
	// local memories: two RAM pages and a ROM
	reg  [31:0] page0_mem [0:WORDS_PER_PAGE-1];
	reg  [31:0] page1_mem [0:WORDS_PER_PAGE-1];
	reg  [31:0] rom_mem   [0:ROM_WORDS-1];
	integer     k;

	initial begin
		for (k = 0; k < ROM_WORDS; k = k + 1)
			rom_mem[k] = 32'h00000000;
	end

	// ==========================================================
	// page and word select
	// instruction region is 16KB of RAM only; data region adds ROM above it
	wire        ins_page  = ins_off[`PAGE_SEL_BIT];
	wire        dat_page  = dat_off[`PAGE_SEL_BIT];
	wire        dat_rom   = dat_off[`RAM_ROM_SEL_BIT];
	wire [10:0] ins_widx  = ins_off[`PAGE_SEL_BIT-1:`WORD_IDX_LSB];
	wire [10:0] dat_widx  = dat_off[`PAGE_SEL_BIT-1:`WORD_IDX_LSB];
	wire [11:0] rom_widx  = dat_off[`RAM_ROM_SEL_BIT-1:`WORD_IDX_LSB];
	wire        ins_go    = i_ins_req && ins_in;
	wire        dat_go    = i_dat_req && dat_in;
	// the instruction port gets the page on a clash
	wire        clash     = ins_go && dat_go && !dat_rom && (ins_page == dat_page);
	wire        dat_serve = dat_go && !clash;

	// ==========================================================
	// region state for the processor
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_ins_region_on <= 1'b0;
			o_dat_region_on <= 1'b0;
		end else if (i_ce) begin
			o_ins_region_on <= ins_en_reg;
			o_dat_region_on <= dat_en_reg;
		end
	end

	// ==========================================================
	// instruction port answer
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_ins_rdata <= 32'h00000000;
			o_ins_hit   <= 1'b0;
			o_ins_ack   <= 1'b0;
		end else if (i_ce) begin
			o_ins_hit <= ins_go;
			o_ins_ack <= i_ins_req;
			if (ins_go)
				o_ins_rdata <= ins_page ? page1_mem[ins_widx] : page0_mem[ins_widx];
			else
				o_ins_rdata <= 32'h00000000;
		end
	end

	// ==========================================================
	// data port answer
	always @(posedge i_clk) begin
		if (i_rst) begin
			o_dat_rdata <= 32'h00000000;
			o_dat_hit   <= 1'b0;
			o_dat_ack   <= 1'b0;
		end else if (i_ce) begin
			o_dat_hit <= dat_go;
			o_dat_ack <= i_dat_req && !clash;
			if (dat_serve && !i_dat_we) begin
				if (dat_rom)
					o_dat_rdata <= rom_mem[rom_widx];
				else
					o_dat_rdata <= dat_page ? page1_mem[dat_widx] : page0_mem[dat_widx];
			end else begin
				o_dat_rdata <= 32'h00000000;
			end
		end
	end

	// ==========================================================
	// RAM writes; ROM half ignores writes
	always @(posedge i_clk) begin
		if (i_ce && !i_rst && dat_serve && i_dat_we && !dat_rom) begin
			if (dat_page)
				page1_mem[dat_widx] <= i_dat_wdata;
			else
				page0_mem[dat_widx] <= i_dat_wdata;
		end
	end

endmodule // local_memory_region_regs

`default_nettype wire

// ### bench/region_checker.sv
// assertions for the region setup registers and local memories
// assumes binding into local_memory_region_regs, all on its one clock
`timescale 1ns/10ps
`default_nettype none
module region_checker (
	input wire logic        i_clk, i_rst, i_ce, i_cp_wr, i_cp_rd, i_ins_req, i_dat_req, i_dat_we,
	input wire logic [2:0]  i_cp_op2,
	input wire logic [31:0] i_cp_wdata, o_cp_rdata, i_ins_addr, i_dat_addr, o_dat_rdata,
	input wire logic        o_ins_ack, o_dat_ack
);
	// ==========
	// properties
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	wire rd = i_ce & i_cp_rd;
	sequence s_wr_rd(op);
		i_ce && i_cp_wr && i_cp_op2 == op ##1 rd && i_cp_op2 == op && !i_cp_wr;
	endsequence
	property p_back(op);
		s_wr_rd(op) |=> (o_cp_rdata & 32'hfffff001) == ($past(i_cp_wdata, 2) & 32'hfffff001);
	endproperty
	a_isize_fixed: assert property (rd && i_cp_op2 == 3'h1 |=> o_cp_rdata[5:2] == 4'h5)
		else $error("instruction size code wrong");
	a_dsize_fixed: assert property (rd && i_cp_op2 == 3'h0 |=> o_cp_rdata[5:2] == 4'h6)
		else $error("data size code wrong");
	a_resv_zero: assert property (rd |=> o_cp_rdata[11:6] == 6'h00 && !o_cp_rdata[1])
		else $error("reserved bits not zero");
	a_bad_op2: assert property (rd && i_cp_op2 > 3'h1 |=> o_cp_rdata == 32'h0)
		else $error("unselected register read not zero");
	a_dat_back: assert property (p_back(3'h0))
		else $error("data region base or enable lost");
	a_ins_back: assert property (p_back(3'h1))
		else $error("instruction region base or enable lost");
	a_ins_ack: assert property (i_ce && i_ins_req |=> o_ins_ack)
		else $error("fetch not answered");
	a_apart_pages: assert property (i_ce && i_ins_req && i_dat_req && i_ins_addr[13] != i_dat_addr[13]
		|=> o_dat_ack)
		else $error("parallel access on two pages refused");
	a_rom_zero: assert property (i_ce && i_dat_req && !i_dat_we && i_dat_addr[31:14] == 18'h3
		|=> o_dat_rdata == 32'h0)
		else $error("read only half changed");
endmodule // region_checker
bind local_memory_region_regs region_checker i_chk (
	.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_cp_wr(i_cp_wr), .i_cp_rd(i_cp_rd), .i_ins_req(i_ins_req),
	.i_dat_req(i_dat_req), .i_dat_we(i_dat_we), .i_cp_op2(i_cp_op2), .i_cp_wdata(i_cp_wdata),
	.o_cp_rdata(o_cp_rdata), .i_ins_addr(i_ins_addr), .i_dat_addr(i_dat_addr), .o_dat_rdata(o_dat_rdata),
	.o_ins_ack(o_ins_ack), .o_dat_ack(o_dat_ack)
);
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the region setup registers and local memories
// assumes design and checker compiled first
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        i_clk = 0, i_rst = 1, i_ce = 1, i_cp_wr = 0, i_cp_rd = 0, i_ins_req = 0, i_dat_req = 0, i_dat_we = 0;
	logic [2:0]  i_cp_op2 = 0;
	logic [31:0] i_cp_wdata = 0, i_ins_addr = 0, i_dat_addr = 0, i_dat_wdata = 0;
	wire  [31:0] o_cp_rdata, o_ins_rdata, o_dat_rdata;
	wire         o_ins_hit, o_ins_ack, o_dat_hit, o_dat_ack, o_ins_region_on, o_dat_region_on;
	int          errors = 0, n_compared = 0, cycles = 0;
	// ==========
	// harness
	always #25 i_clk = ~i_clk;
	local_memory_region_regs i_dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_cp_wr(i_cp_wr), .i_cp_rd(i_cp_rd), .i_cp_op2(i_cp_op2),
		.i_cp_wdata(i_cp_wdata), .o_cp_rdata(o_cp_rdata),
		.i_ins_req(i_ins_req), .i_ins_addr(i_ins_addr), .o_ins_rdata(o_ins_rdata), .o_ins_hit(o_ins_hit),
		.o_ins_ack(o_ins_ack),
		.i_dat_req(i_dat_req), .i_dat_we(i_dat_we), .i_dat_addr(i_dat_addr), .i_dat_wdata(i_dat_wdata),
		.o_dat_rdata(o_dat_rdata), .o_dat_hit(o_dat_hit), .o_dat_ack(o_dat_ack),
		.o_ins_region_on(o_ins_region_on), .o_dat_region_on(o_dat_region_on)
	);
	always @(posedge i_clk) if (++cycles > 400) begin
		errors++;
		tally_and_finish;
	end
	task tally_and_finish;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task cp(input logic w, r, input logic [2:0] op, input logic [31:0] d);
		{i_cp_wr, i_cp_rd, i_cp_op2, i_cp_wdata} = {w, r, op, d};
		@(posedge i_clk) #1;
	endtask
	task mem(input logic ir, dr, dw, input logic [31:0] ia, da, dd);
		{i_ins_req, i_dat_req, i_dat_we, i_ins_addr, i_dat_addr, i_dat_wdata} = {ir, dr, dw, ia, da, dd};
		@(posedge i_clk) #1;
	endtask
	// ==========
	// scenarios
	task t_reset;
		cp(0, 1, 0, 0); chk(o_cp_rdata, 32'h18);
		cp(0, 1, 1, 0); chk(o_cp_rdata, 32'h14);
		chk({o_ins_region_on, o_dat_region_on}, 0);
	endtask
	task t_fields;
		cp(1, 0, 0, '1); cp(0, 1, 0, 0); chk(o_cp_rdata, 32'hfffff019);
		cp(1, 0, 1, '1); cp(0, 1, 1, 0); chk(o_cp_rdata, 32'hfffff015);
		cp(1, 0, 2, '1); cp(0, 1, 2, 0); chk(o_cp_rdata, 0);
	endtask
	task t_program;
		cp(1, 0, 1, 32'h1); cp(1, 0, 0, 32'h8001);
		cp(0, 1, 0, 0); chk(o_cp_rdata, 32'h8019);
		cp(0, 1, 1, 0); chk(o_cp_rdata, 32'h15);
		cp(0, 0, 0, 0); chk({o_ins_region_on, o_dat_region_on}, 3);
	endtask
	task t_mem;
		mem(0, 1, 1, 0, 32'h8000, 32'h1234abcd); chk({o_dat_ack, o_dat_hit}, 3);
		mem(1, 1, 1, 0, 32'ha004, 32'h55aa55aa); chk(o_ins_rdata, 32'h1234abcd);
		chk({o_ins_ack, o_dat_ack}, 3);
		mem(1, 0, 0, 32'h2004, 0, 0); chk(o_ins_rdata, 32'h55aa55aa);
		chk(o_ins_hit, 1);
		mem(1, 1, 1, 0, 32'h8000, 0); chk(o_dat_ack, 0);
		mem(0, 1, 1, 0, 32'hc000, '1); chk({o_dat_ack, o_dat_hit}, 3);
		mem(0, 1, 0, 0, 32'hc000, 0); chk(o_dat_rdata, 0);
		mem(0, 1, 0, 0, 32'h8000, 0); chk(o_dat_rdata, 32'h1234abcd);
		mem(1, 1, 0, 32'h4000, 32'h10000, 0); chk({o_ins_ack, o_ins_hit, o_dat_ack, o_dat_hit}, 4'ha);
		mem(0, 0, 0, 0, 0, 0);
	endtask
	task t_freeze;
		i_ce = 0;
		cp(1, 0, 1, 0); cp(0, 1, 0, 0); chk(o_cp_rdata, 32'h15);
		chk({o_ins_region_on, o_dat_region_on}, 3);
		i_ce = 1;
		cp(0, 1, 1, 0); chk(o_cp_rdata, 32'h15);
	endtask
	task t_rerun;
		i_rst = 1;
		cp(0, 0, 0, 0); chk(o_cp_rdata, 0);
		i_rst = 0;
		cp(0, 1, 1, 0); chk(o_cp_rdata, 32'h14);
		chk({o_ins_region_on, o_dat_region_on}, 0);
		cp(0, 1, 0, 0); chk(o_cp_rdata, 32'h18);
	endtask
	initial begin
		repeat (8) @(posedge i_clk);
		#1 i_rst = 0;
		t_reset;
		t_fields;
		t_program;
		t_mem;
		t_freeze;
		t_rerun;
		tally_and_finish;
	end
endmodule // testbench
`default_nettype wire
